// >>> verilog/fpsf_core.sv
// fpsf_core: issue stall, serialization, interrupt and forwarding control of the fp coprocessor
`timescale 1ns/1ps
// ==========================================================
`include "fpsf_defs.svh"
module fpsf_core #(
  parameter int          RW       = 5,
  parameter int          CW       = 7,
  parameter int          XW       = 4,
  parameter logic [31:0] ID_VALUE = `FPSF_ID_VALUE
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // issue stage, fed by the host prefetch path only
  input  wire logic                 issueValid,
  input  wire fpsf_pkg::fpsf_class_t issueClass,
  input  wire logic                 issueDbl,
  input  wire logic [RW-1:0]        issueDst,
  input  wire logic [RW-1:0]        issueSrcA,
  input  wire logic [RW-1:0]        issueSrcB,
  input  wire logic [2:0]           issueVecLen,
  input  wire fpsf_pkg::fpsf_creg_t issueCreg,
  input  wire logic [31:0]          issueWrData,
  // host pipeline events
  input  wire logic                 hostCondFail,
  input  wire logic                 hostFlowIrq,
  input  wire logic                 hostDataAbort,
  input  wire logic                 memXfer,
  // datapath
  input  wire logic [3:0]           cmpFlagsIn,
  // issue handshake
  output logic                      hostStall,
  output logic                      issueAccept,
  output logic                      issueReject,
  // forwarding and transfers
  output logic                      fwdSrcA,
  output logic                      fwdSrcB,
  output logic [31:0]               ctrlRdData,
  output logic                      ctrlRdValid,
  // status
  output logic                      unitEnable,
  output logic                      lsRestart,
  output logic [XW-1:0]             lsXferIdx,
  output logic                      coprocBusyIrq,
  output logic [2:0]                pipeBusy
);
  import fpsf_pkg::*;

  // ==========================================================
  // declarations
  fpsf_state_t   state;
  fpsf_state_t   next_state;
  logic          isLs, isMac, isDs, isDp, isSer, isCtrl, useA, useB, useD;
  logic          lsBusy, lsLock, lsDbl, lsFwd, lsWb;
  logic          macBusy, macLock, macDbl, macFwd, macTag, macWb;
  logic          dsBusy, dsLock, dsDbl, dsFwd;
  logic [CW-1:0] lsRem, macRem, dsRem, dsCyc;
  logic [RW-1:0] lsReg, macReg, dsReg, holdReg;
  logic          hold, holdDbl, lsAbort, allIdle, serOk, resBusy, stall, cancel;
  logic          hazA, hazB, hazD, fwdA, fwdB, okFwd;
  logic [3:0]    pLock, pDbl, pFwd;
  logic [RW-1:0] pReg [4];
  logic [CW-1:0] pRem [4];
  logic [31:0]   scReg, excReg, eiReg, piReg;
  logic [CW-1:0] irqCnt;

  // ==========================================================
  // register overlap, single index s or double index d covering 2d and 2d+1
  function automatic logic ovl(input logic [RW-1:0] a, input logic ad,
                               input logic [RW-1:0] b, input logic bd);
    if (ad || bd) begin
      ovl = (ad ? a[RW-2:0] : a[RW-1:1]) == (bd ? b[RW-2:0] : b[RW-1:1]);
    end else begin
      ovl = (a == b);
    end
  endfunction : ovl

  // ==========================================================
  // classify the instruction in issue
  always_comb begin
    isLs = 1'b0; isMac = 1'b0; isDs = 1'b0; isSer = 1'b0;
    useA = 1'b0; useB = 1'b0; useD = 1'b0;
    case (issueClass)
      CL_LOAD, CL_LDM: begin
        isLs = 1'b1; useD = 1'b1;
      end
      CL_STORE, CL_STM, CL_TOHOST: begin
        isLs = 1'b1; useA = 1'b1;
      end
      CL_MAC: begin
        isMac = 1'b1; useA = 1'b1; useB = 1'b1; useD = 1'b1;
      end
      CL_CMP: begin
        isMac = 1'b1; useA = 1'b1; useB = 1'b1;
      end
      CL_DS: begin
        isDs = 1'b1; useA = 1'b1; useB = 1'b1; useD = 1'b1;
      end
      CL_WCTRL, CL_RCTRL, CL_FLAGX: isSer = 1'b1;
      default: isSer = 1'b0;
    endcase
  end
  assign isDp   = isMac || isDs;
  assign isCtrl = isSer;

  // ==========================================================
  // independent pipes: load/store, multiply-accumulate, divide/sqrt
  // each pipe has its own tracker so transfers overlap arithmetic
  assign dsCyc = ({4'h0, issueVecLen} + CW'(1)) * `FPSF_DS_ITER_CYC + `FPSF_DS_TAIL_CYC;
  assign lsAbort = hostDataAbort && lsBusy;

  fpsf_pipe_track #(.RW(RW), .CW(CW)) u_ls (
    .clk       (clk),
    .arst_n    (arst_n),
    .start     (issueAccept && isLs),
    .startCyc  (`FPSF_LS_LAT + {4'h0, issueVecLen}),
    .startReg  (useD ? issueDst : issueSrcA),
    .startDbl  (issueDbl),
    .startLock (issueClass != CL_TOHOST),
    .startFwd  (useD),
    .startTag  (1'b0),
    .cancel    (lsAbort),
    .busy      (lsBusy),
    .lock      (lsLock),
    .remain    (lsRem),
    .lockReg   (lsReg),
    .dbl       (lsDbl),
    .fwd       (lsFwd),
    .tag       (),
    .wb        (lsWb)
  );

  fpsf_pipe_track #(.RW(RW), .CW(CW)) u_mac (
    .clk       (clk),
    .arst_n    (arst_n),
    .start     (issueAccept && isMac),
    .startCyc  (`FPSF_MAC_LAT + {4'h0, issueVecLen}),
    .startReg  (issueDst),
    .startDbl  (issueDbl),
    .startLock (useD),
    .startFwd  (useD),
    .startTag  (issueClass == CL_CMP),
    .cancel    (1'b0),
    .busy      (macBusy),
    .lock      (macLock),
    .remain    (macRem),
    .lockReg   (macReg),
    .dbl       (macDbl),
    .fwd       (macFwd),
    .tag       (macTag),
    .wb        (macWb)
  );

  // never cancelled: once in execute an op runs to its end
  fpsf_pipe_track #(.RW(RW), .CW(CW)) u_ds (
    .clk       (clk),
    .arst_n    (arst_n),
    .start     (issueAccept && isDs),
    .startCyc  (dsCyc),
    .startReg  (issueDst),
    .startDbl  (issueDbl),
    .startLock (1'b1),
    .startFwd  (1'b1),
    .startTag  (1'b0),
    .cancel    (1'b0),
    .busy      (dsBusy),
    .lock      (dsLock),
    .remain    (dsRem),
    .lockReg   (dsReg),
    .dbl       (dsDbl),
    .fwd       (dsFwd),
    .tag       (),
    .wb        ()
  );

  fpsf_ls_restart #(.RW(RW), .XW(XW)) u_rst (
    .clk     (clk),
    .arst_n  (arst_n),
    .lsStart (issueAccept && isLs),
    .abort   (lsAbort),
    .lsWb    (lsWb),
    .memXfer (memXfer),
    .lsReg   (lsReg),
    .lsDbl   (lsDbl),
    .lsLock  (lsLock),
    .hold    (hold),
    .holdReg (holdReg),
    .holdDbl (holdDbl),
    .restart (lsRestart),
    .xferIdx (lsXferIdx)
  );

  // ==========================================================
  // producers seen by the hazard check; index 3 is the abort hold
  assign pLock = {hold, dsLock, macLock, lsLock};
  assign pDbl  = {holdDbl, dsDbl, macDbl, lsDbl};
  assign pFwd  = {1'b0, dsFwd, macFwd, lsFwd};
  assign pReg  = '{lsReg, macReg, dsReg, holdReg};
  assign pRem  = '{lsRem, macRem, dsRem, '0};

  // a forwardable result frees its consumer in its writeback cycle, one cycle early
  always_comb begin
    hazA = 1'b0; hazB = 1'b0; hazD = 1'b0;
    fwdA = 1'b0; fwdB = 1'b0; okFwd = 1'b0;
    for (int i = 0; i < 4; i++) begin
      okFwd = 1'b0;
      // the reissued load/store must pass its own hold
      if (pLock[i] && !(i == 3 && isLs)) begin
        // stores and host transfers are not dp, so they wait for writeback
        okFwd = pFwd[i] && isDp && (pDbl[i] == issueDbl) && (pRem[i] == CW'(1));
        if (useA && ovl(issueSrcA, issueDbl, pReg[i], pDbl[i])) begin
          if (okFwd) fwdA = 1'b1;
          else hazA = 1'b1;
        end
        if (useB && ovl(issueSrcB, issueDbl, pReg[i], pDbl[i])) begin
          if (okFwd) fwdB = 1'b1;
          else hazB = 1'b1;
        end
        if (useD && ovl(issueDst, issueDbl, pReg[i], pDbl[i])) hazD = 1'b1;
      end
    end
  end

  // an arithmetic pipe takes its next op in the writeback cycle of the last one,
  // otherwise a forwarded operand could never save its cycle
  assign resBusy = (isLs && lsBusy) || (isMac && macRem > CW'(1)) || (isDs && dsRem > CW'(1));
  assign allIdle = !lsBusy && !macBusy && !dsBusy;

  // ==========================================================
  // serializing release conditions
  always_comb begin
    serOk = allIdle;
    if (issueClass == CL_WCTRL) begin
      if (issueCreg == CR_SC) serOk = !macBusy && !dsBusy;
      else if (issueCreg == CR_ID) serOk = allIdle;
      else serOk = allIdle && !hold;
    end
  end

  // ==========================================================
  // issue handshake; a host condition failure or interrupt discards the instruction in issue
  assign cancel      = hostCondFail || hostFlowIrq;
  assign stall       = isSer ? !serOk : (hazA || hazB || hazD || resBusy);
  // while disabled only control transfers go through, so the unit can be re-enabled
  assign issueReject = issueValid && !unitEnable && !isCtrl && !cancel;
  assign hostStall   = issueValid && !cancel && !issueReject && stall;
  assign issueAccept = issueValid && !cancel && !issueReject && !stall;

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: if (hostStall && isSer) next_state = ST_SER;
      ST_SER: if (!hostStall) next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) state <= ST_RUN;
    else state <= next_state;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fwdSrcA <= 1'b0;
      fwdSrcB <= 1'b0;
    end else begin
      fwdSrcA <= issueAccept && fwdA;
      fwdSrcB <= issueAccept && fwdB;
    end
  end

  // ==========================================================
  // control registers; the identification value has no storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scReg  <= `FPSF_SC_RST;
      excReg <= `FPSF_EXC_RST;
      eiReg  <= `FPSF_EI_RST;
      piReg  <= `FPSF_PI_RST;
    end else begin
      if (issueAccept && issueClass == CL_WCTRL) begin
        if (issueCreg == CR_SC) scReg <= issueWrData;
        else if (issueCreg == CR_EXC) excReg <= issueWrData;
        else if (issueCreg == CR_EI) eiReg <= issueWrData;
        else if (issueCreg == CR_PI) piReg <= issueWrData;
      end
      if (macWb && macTag) scReg[`FPSF_FLAG_MSB:`FPSF_FLAG_LSB] <= cmpFlagsIn;
    end
  end
  assign unitEnable = excReg[`FPSF_EN_BIT];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlRdData  <= '0;
      ctrlRdValid <= 1'b0;
    end else begin
      ctrlRdValid <= issueAccept && (issueClass == CL_RCTRL || issueClass == CL_FLAGX);
      if (issueAccept && issueClass == CL_FLAGX) begin
        ctrlRdData <= {scReg[`FPSF_FLAG_MSB:`FPSF_FLAG_LSB], 28'h0000000};
      end else if (issueAccept && issueClass == CL_RCTRL) begin
        if (issueCreg == CR_SC) ctrlRdData <= scReg;
        else if (issueCreg == CR_EXC) ctrlRdData <= excReg;
        else if (issueCreg == CR_EI) ctrlRdData <= eiReg;
        else if (issueCreg == CR_PI) ctrlRdData <= piReg;
        else ctrlRdData <= ID_VALUE;
      end
    end
  end

  // ==========================================================
  // unavailability after a host interrupt, bounded by the longest divide
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      coprocBusyIrq <= 1'b0;
      irqCnt        <= '0;
    end else if (hostFlowIrq && !allIdle) begin
      coprocBusyIrq <= 1'b1;
      irqCnt        <= '0;
    end else if (allIdle) begin
      coprocBusyIrq <= 1'b0;
      irqCnt        <= '0;
    end else if (coprocBusyIrq && irqCnt != '1) begin
      irqCnt <= irqCnt + CW'(1);
    end
  end
  assign pipeBusy = {dsBusy, macBusy, lsBusy};

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_SER_STALL: assert property (
    issueValid && isSer && !allIdle && !cancel && issueClass != CL_WCTRL |-> hostStall)
    else $error("serializing read not stalled while pipes busy");
  AST_SER_RELEASE: assert property (
    issueAccept && issueClass == CL_RCTRL |-> !macBusy && !dsBusy && !lsBusy)
    else $error("control read released with ops in flight");
  AST_RD_VALID: assert property (
    issueAccept && issueClass == CL_RCTRL |=> ctrlRdValid)
    else $error("control read gave no data");
  AST_CMP_WB: assert property (
    macWb && macTag |=> scReg[31:28] == $past(cmpFlagsIn) && $past(macRem) == CW'(1))
    else $error("compare flags not written at writeback");
  AST_SC_WRITE: assert property (
    issueAccept && issueClass == CL_WCTRL && issueCreg == CR_SC |-> !macBusy && !dsBusy)
    else $error("status control write while arithmetic in flight");
  AST_EXC_EMPTY: assert property (
    issueAccept && issueClass == CL_WCTRL && issueCreg inside {CR_EXC, CR_EI, CR_PI}
    |-> allIdle && !hold)
    else $error("exception-side write with pipeline not empty");
  AST_ID_READ: assert property (
    issueAccept && issueClass == CL_RCTRL && issueCreg == CR_ID |=> ctrlRdData == ID_VALUE)
    else $error("identification value changed");
  AST_IRQ_DROP: assert property (
    hostFlowIrq |-> !issueAccept && !hostStall)
    else $error("instruction issued across host interrupt");
  AST_COND_CANCEL: assert property (
    hostCondFail |-> !issueAccept ##1 !ctrlRdValid)
    else $error("condition-failed instruction not cancelled");
  AST_ABORT_RESTART: assert property (
    lsAbort |=> lsRestart && !lsBusy)
    else $error("aborted load/store not flushed for restart");
  AST_XFER_FIRST: assert property (
    lsRestart |-> lsXferIdx == '0)
    else $error("restart not from first transfer");
  AST_DS_RUN: assert property (
    dsRem > CW'(1) && hostFlowIrq |=> dsRem == $past(dsRem) - CW'(1))
    else $error("vector divide interrupted");
  AST_IRQ_BOUND: assert property (
    coprocBusyIrq |-> irqCnt <= `FPSF_DS_MAX_CYC)
    else $error("coprocessor unavailable too long");
  AST_NO_FWD_STORE: assert property (
    issueAccept && !isDp |=> !fwdSrcA && !fwdSrcB)
    else $error("forwarded into store or host transfer");
  AST_EN_OFF: assert property (
    issueValid && !unitEnable && !isCtrl && !cancel |-> issueReject && !issueAccept)
    else $error("instruction accepted while unit disabled");

  COV_SER: cover property (state == ST_SER ##1 state == ST_RUN);
  COV_FWD: cover property (fwdSrcA);
  COV_ABORT: cover property (lsAbort ##1 hold);
  COV_IRQ: cover property (coprocBusyIrq && dsBusy);

endmodule : fpsf_core

// >>> verilog/fpsf_defs.svh
// fpsf_defs.svh: clock period, field positions, reset values and cycle counts of the fp control block
`ifndef FPSF_DEFS_SVH
`define FPSF_DEFS_SVH

// ==========================================================
// clock
`define FPSF_CLK_NS       100

// ==========================================================
// pipeline latencies in cycles of clk
`define FPSF_LS_LAT       7'h03
`define FPSF_MAC_LAT      7'h08
`define FPSF_DS_ITER_CYC  7'h0E
`define FPSF_DS_TAIL_CYC  7'h02
// worst case: eight iterations * 14 + 2 = 114 cycles after entering execute 1
`define FPSF_DS_MAX_CYC   7'h72

// ==========================================================
// control register fields and reset values
`define FPSF_EN_BIT       30
`define FPSF_FLAG_MSB     31
`define FPSF_FLAG_LSB     28
`define FPSF_EXC_RST      32'h00000000
`define FPSF_SC_RST       32'h00000000
`define FPSF_EI_RST       32'h00000000
`define FPSF_PI_RST       32'h00000000
// identification value is arbitrary
`define FPSF_ID_VALUE     32'h5A5A0001

`endif

// >>> verilog/fpsf_pkg.sv
// fpsf_pkg: types shared by the fp coprocessor pipeline control files
package fpsf_pkg;

  // ==========================================================
  // instruction classes seen in the issue stage
  typedef enum logic [3:0] {
    CL_NONE, CL_LOAD, CL_LDM, CL_STORE, CL_STM, CL_MAC, CL_DS, CL_CMP,
    CL_TOHOST, CL_WCTRL, CL_RCTRL, CL_FLAGX
  } fpsf_class_t;

  // ==========================================================
  // control register selector for transfers
  typedef enum logic [2:0] {
    CR_ID, CR_SC, CR_EXC, CR_EI, CR_PI
  } fpsf_creg_t;

  // ==========================================================
  // issue stage state
  typedef enum logic {
    ST_RUN, ST_SER
  } fpsf_state_t;

endpackage : fpsf_pkg

// >>> verilog/fpsf_pipe_track.sv
// fpsf_pipe_track: one in-flight operation of an execution pipe with its destination lock
`timescale 1ns/1ps
module fpsf_pipe_track #(
  parameter int RW = 5,
  parameter int CW = 7
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          arst_n,
  // start and cancel
  input  wire logic          start,
  input  wire logic [CW-1:0] startCyc,
  input  wire logic [RW-1:0] startReg,
  input  wire logic          startDbl,
  input  wire logic          startLock,
  input  wire logic          startFwd,
  input  wire logic          startTag,
  input  wire logic          cancel,
  // state
  output logic               busy,
  output logic               lock,
  output logic [CW-1:0]      remain,
  output logic [RW-1:0]      lockReg,
  output logic               dbl,
  output logic               fwd,
  output logic               tag,
  output logic               wb
);

  logic lockEn;

  // ==========================================================
  // countdown to writeback
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remain <= '0;
    end else if (cancel) begin
      remain <= '0;
    end else if (start) begin
      remain <= startCyc;
    end else if (remain != '0) begin
      remain <= remain - CW'(1);
    end
  end

  // ==========================================================
  // operation attributes held while in flight
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lockReg <= '0;
      dbl     <= 1'b0;
      lockEn  <= 1'b0;
      fwd     <= 1'b0;
      tag     <= 1'b0;
    end else if (start) begin
      lockReg <= startReg;
      dbl     <= startDbl;
      lockEn  <= startLock;
      fwd     <= startFwd;
      tag     <= startTag;
    end
  end

  assign busy = (remain != '0);
  assign lock = busy && lockEn;
  // last cycle before the result reaches the register file
  assign wb   = (remain == CW'(1));

endmodule : fpsf_pipe_track

// >>> verilog/fpsf_ls_restart.sv
// fpsf_ls_restart: abort hold and transfer index for restartable loads and stores
`timescale 1ns/1ps
module fpsf_ls_restart #(
  parameter int RW = 5,
  parameter int XW = 4
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          arst_n,
  // load/store pipe events
  input  wire logic          lsStart,
  input  wire logic          abort,
  input  wire logic          lsWb,
  input  wire logic          memXfer,
  input  wire logic [RW-1:0] lsReg,
  input  wire logic          lsDbl,
  input  wire logic          lsLock,
  // hold and restart state
  output logic               hold,
  output logic [RW-1:0]      holdReg,
  output logic               holdDbl,
  output logic               restart,
  output logic [XW-1:0]      xferIdx
);

  // ==========================================================
  // keep the aborted register locked until the reissued op writes back
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold    <= 1'b0;
      holdReg <= '0;
      holdDbl <= 1'b0;
    end else if (abort) begin
      hold    <= lsLock;
      holdReg <= lsReg;
      holdDbl <= lsDbl;
    end else if (lsWb) begin
      hold    <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      restart <= 1'b0;
    end else begin
      restart <= abort;
    end
  end

  // ==========================================================
  // a reissued multiple transfer begins again at transfer zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xferIdx <= '0;
    end else if (abort || lsStart) begin
      xferIdx <= '0;
    end else if (memXfer) begin
      xferIdx <= xferIdx + XW'(1);
    end
  end

endmodule : fpsf_ls_restart

// >>> test/fpsf_host_model.sv
// fpsf_host_model: host pipeline side that presents coprocessor instructions
`timescale 1ns/1ps
module fpsf_host_model (
  // clock, reset and requests
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic go,
  input  wire logic cancel,
  input  wire logic issueAccept,
  // issue and cycle stamps
  output logic      issueValid,
  output int        cyc,
  output int        acceptCyc
);
  logic took;
  // sampled mid-cycle so the combinational accept has settled
  always @(negedge clk) took = issueValid & issueAccept;
  // ==========================================================
  // instruction held until taken, dropped when the host cancels it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      issueValid <= 1'h0;
      cyc        <= 0;
    end else begin
      cyc <= cyc + 1;
      if (took) acceptCyc <= cyc;
      if (took || cancel) issueValid <= #1 1'h0;
      if (go) issueValid <= #1 1'h1;
    end
  end
endmodule : fpsf_host_model

// >>> test/fpsf_core_tb_top.sv
// fpsf_core_tb_top: directed bench for the fp coprocessor pipeline control
`timescale 1ns/1ps
module fpsf_core_tb_top;
  import fpsf_pkg::*;
  // identification value is arbitrary
  localparam logic [31:0] ID = 32'h0000C0DE;
  logic        clk, arstN, go, condFail, flowIrq, dbl;
  logic        issueValid, issueAccept, fwdSrcA, rdValid, unitEnable, busyIrq;
  logic        abort, xfer, stall, reject, restart;
  logic [3:0]  flags, idx;
  logic [2:0]  busy;
  logic [4:0]  dst, srcA, srcB;
  logic [2:0]  len;
  logic [31:0] wd, rdData;
  fpsf_class_t cls;
  fpsf_creg_t  creg;
  int          cyc, acceptCyc, n_errors, checked, t0;
  fpsf_host_model i_host (.clk(clk), .arst_n(arstN), .go(go), .cancel(condFail),
    .issueAccept(issueAccept), .issueValid(issueValid), .cyc(cyc), .acceptCyc(acceptCyc));
  fpsf_core #(.ID_VALUE(ID)) i_dut (.clk(clk), .arst_n(arstN), .issueValid(issueValid),
    .issueClass(cls), .issueDbl(dbl), .issueDst(dst), .issueSrcA(srcA), .issueSrcB(srcB),
    .issueVecLen(len), .issueCreg(creg), .issueWrData(wd), .hostCondFail(condFail),
    .hostFlowIrq(flowIrq), .hostDataAbort(abort), .memXfer(xfer), .cmpFlagsIn(flags),
    .hostStall(stall), .issueAccept(issueAccept), .issueReject(reject), .fwdSrcA(fwdSrcA),
    .fwdSrcB(), .ctrlRdData(rdData), .ctrlRdValid(rdValid), .unitEnable(unitEnable),
    .lsRestart(restart), .lsXferIdx(idx), .coprocBusyIrq(busyIrq), .pipeBusy(busy));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // returns at the falling edge after the instruction was taken
  task automatic issue(input fpsf_class_t c, input logic d, input logic [4:0] r,
                       input logic [4:0] a, input logic [2:0] l, input fpsf_creg_t g,
                       input logic [31:0] w);
    int n;
    n = 0;
    @(posedge clk) #1;
    cls = c;
    dbl = d;
    dst = r;
    srcA = a;
    len = l;
    creg = g;
    wd = w;
    go = 1'h1;
    @(posedge clk) #1;
    go = 1'h0;
    do begin
      @(negedge clk);
      n++;
      if (issueValid) chk(stall, !(issueAccept || reject));
    end while (issueValid && n < 300);
    if (n >= 300) begin
      n_errors++;
      end_of_test();
    end
  endtask : issue
  // ==========================================================
  // scenarios
  task automatic t_ctrl();
    chk(unitEnable, 1'h0);
    issue(CL_WCTRL, 1'h0, 5'h00, 5'h00, 3'h0, CR_EXC, 32'h40000000);
    chk(unitEnable, 1'h1);
    issue(CL_WCTRL, 1'h0, 5'h00, 5'h00, 3'h0, CR_ID, 32'h00000000);
    issue(CL_RCTRL, 1'h0, 5'h00, 5'h00, 3'h0, CR_ID, 32'h00000000);
    chk(rdValid, 1'h1);
    chk(rdData, ID);
    $display("test ctrl done");
  endtask : t_ctrl
  task automatic t_fwd();
    issue(CL_MAC, 1'h0, 5'h05, 5'h01, 3'h0, CR_SC, 32'h0);
    t0 = acceptCyc;
    issue(CL_MAC, 1'h0, 5'h06, 5'h05, 3'h0, CR_SC, 32'h0);
    // accept edges apart: one more than the stall cycles of a back-to-back issue
    chk(acceptCyc - t0, 8);
    chk(fwdSrcA, 1'h1);
    t0 = acceptCyc;
    issue(CL_STORE, 1'h0, 5'h06, 5'h06, 3'h0, CR_SC, 32'h0);
    chk(acceptCyc - t0, 9);
    chk(fwdSrcA, 1'h0);
    // double D2 overlaps single S5
    issue(CL_MAC, 1'h1, 5'h02, 5'h00, 3'h0, CR_SC, 32'h0);
    t0 = acceptCyc;
    issue(CL_MAC, 1'h0, 5'h08, 5'h05, 3'h0, CR_SC, 32'h0);
    chk(acceptCyc - t0, 9);
    chk(fwdSrcA, 1'h0);
    $display("test fwd done");
  endtask : t_fwd
  task automatic t_ds();
    issue(CL_DS, 1'h0, 5'h0A, 5'h0C, 3'h7, CR_SC, 32'h0);
    t0 = acceptCyc;
    issue(CL_LOAD, 1'h0, 5'h14, 5'h00, 3'h0, CR_SC, 32'h0);
    chk(acceptCyc - t0 < 5, 1'h1);
    @(posedge clk) #1;
    flowIrq = 1'h1;
    @(posedge clk) #1;
    flowIrq = 1'h0;
    @(negedge clk);
    chk(busyIrq, 1'h1);
    issue(CL_RCTRL, 1'h0, 5'h00, 5'h00, 3'h0, CR_SC, 32'h0);
    // 114 busy cycles, then the read is taken in the first idle one
    chk(acceptCyc - t0, 115);
    chk(rdValid, 1'h1);
    $display("test ds done");
  endtask : t_ds
  task automatic t_cancel();
    @(posedge clk) #1;
    cls = CL_WCTRL;
    creg = CR_SC;
    wd = 32'h00C00000;
    go = 1'h1;
    @(posedge clk) #1;
    go = 1'h0;
    condFail = 1'h1;
    @(negedge clk);
    chk(issueAccept, 1'h0);
    @(posedge clk) #1;
    condFail = 1'h0;
    issue(CL_RCTRL, 1'h0, 5'h00, 5'h00, 3'h0, CR_SC, 32'h0);
    chk(rdData, 32'h00000000);
    $display("test cancel done");
  endtask : t_cancel
  task automatic t_abort();
    issue(CL_LDM, 1'h0, 5'h10, 5'h00, 3'h3, CR_SC, 32'h0);
    @(posedge clk) #1;
    xfer = 1'h1;
    @(posedge clk) #1;
    xfer = 1'h0;
    abort = 1'h1;
    chk(idx, 4'h1);
    @(posedge clk) #1;
    abort = 1'h0;
    chk(restart, 1'h1);
    chk(idx, 4'h0);
    chk(busy, 3'h0);
    // reissue from the first transfer; its dependant waits for the writeback
    issue(CL_LDM, 1'h0, 5'h10, 5'h00, 3'h3, CR_SC, 32'h0);
    t0 = acceptCyc;
    issue(CL_MAC, 1'h0, 5'h01, 5'h10, 3'h0, CR_SC, 32'h0);
    chk(acceptCyc - t0 > 5, 1'h1);
    $display("test abort done");
  endtask : t_abort
  task automatic t_cmp();
    flags = 4'h9;
    issue(CL_CMP, 1'h0, 5'h00, 5'h01, 3'h0, CR_SC, 32'h0);
    issue(CL_FLAGX, 1'h0, 5'h00, 5'h00, 3'h0, CR_SC, 32'h0);
    chk(rdData, 32'h90000000);
    $display("test cmp done");
  endtask : t_cmp
  task automatic t_off();
    // software turns the unit off when a service routine needs no fp work
    issue(CL_WCTRL, 1'h0, 5'h00, 5'h00, 3'h0, CR_EXC, 32'h00000000);
    chk(unitEnable, 1'h0);
    @(posedge clk) #1;
    cls = CL_MAC;
    go = 1'h1;
    @(posedge clk) #1;
    go = 1'h0;
    @(negedge clk);
    chk(reject, 1'h1);
    chk(issueAccept, 1'h0);
    @(posedge clk) #1;
    condFail = 1'h1;
    @(posedge clk) #1;
    condFail = 1'h0;
    $display("test off done");
  endtask : t_off
  initial begin
    {arstN, go, condFail, flowIrq, abort, xfer, flags, dbl, len, dst, srcA, wd} = '0;
    srcB = 5'h1F;
    cls = CL_NONE;
    creg = CR_SC;
    repeat (4) @(posedge clk);
    #1 arstN = 1'h1;
    t_ctrl();
    t_fwd();
    t_ds();
    t_abort();
    t_cancel();
    t_cmp();
    t_off();
    end_of_test();
  end
endmodule : fpsf_core_tb_top
